//--- common/sfr_pkg.sv
// constants and types for the serial flash read path
// Behaviour
// (RULE1) memory reads take a 24-bit byte address
// (RULE2) host sends select, command, three address bytes
// (RULE3) every address bit sampled on rising clock
// (RULE4) address advances after each byte shifted out
// (RULE5) raised select ends read, outputs released
// (RULE6) fast read adds dummy clocks after address
// (RULE7) supported reads behave alike in every protocol; in extended protocol the code gives each read its own lines and dummy count
// (RULE8) extended 2-line io read: eight dummies, mode bit
// (RULE9) dual protocol fast read: eight dummies, two lines
// (RULE10) quad protocol fast read: ten dummies, four lines
// (RULE11) table byte 40h flags dual, quad support
// (RULE12) erase type 1: 4 KB, 0Ch, 20h
// (RULE13) erase type 2: 64 KB; types 3-4 zero
// (RULE14) reserved table bytes read all ones
// (RULE15) address wraps to zero past top location
package sfr_pkg;

    // ****************************************
    // geometry
    // ****************************************
    localparam int          ADDR_W     = 24;          // host address width
    localparam int          MEM_AW     = 21;          // 2 MB array index width
    localparam int          MEM_BYTES  = 2097152;     // array depth in bytes

    // ****************************************
    // protocol select codes
    // ****************************************
    localparam logic [1:0]  PROTO_EXT  = 2'h0;        // command on one line
    localparam logic [1:0]  PROTO_DUAL = 2'h1;        // everything on two lines
    localparam logic [1:0]  PROTO_QUAD = 2'h2;        // everything on four lines

    // ****************************************
    // command codes
    // ****************************************
    localparam logic [7:0]  CMD_READ   = 8'h03;       // plain read
    localparam logic [7:0]  CMD_FAST   = 8'h0b;       // fast read
    localparam logic [7:0]  CMD_DOUT   = 8'h3b;       // dual output fast read
    localparam logic [7:0]  CMD_DIO    = 8'hbb;       // dual io fast read
    localparam logic [7:0]  CMD_QOUT   = 8'h6b;       // quad output fast read
    localparam logic [7:0]  CMD_QIO    = 8'heb;       // quad io fast read
    localparam logic [7:0]  CMD_TABLE  = 8'h5a;       // parameter table read

    // ****************************************
    // dummy clock counts and bit counts
    // ****************************************
    localparam logic [4:0]  DUMMY_NONE = 5'h00;       // plain read
    localparam logic [4:0]  DUMMY_STD  = 5'h08;       // eight dummy clocks
    localparam logic [4:0]  DUMMY_QUAD = 5'h0a;       // ten dummy clocks
    localparam logic [4:0]  CMD_BITS   = 5'h08;       // command length
    localparam logic [4:0]  ADDR_BITS  = 5'h18;       // address length
    localparam logic [3:0]  BYTE_BITS  = 4'h8;        // data byte length

    // ****************************************
    // parameter table contents
    // ****************************************
    localparam logic [7:0]  TBL_3E = 8'h28;           // 001b mode, 01000b dummies
    localparam logic [7:0]  TBL_3F = 8'hbb;           // dual io read code
    localparam logic [7:0]  TBL_40 = 8'hff;           // dual+quad support, rsvd ones
    localparam logic [7:0]  TBL_46 = 8'h28;           // dual protocol: 001b, 01000b
    localparam logic [7:0]  TBL_47 = 8'hbb;           // dual protocol read code
    localparam logic [7:0]  TBL_4A = 8'h2a;           // quad protocol: 001b, 01010b
    localparam logic [7:0]  TBL_4B = 8'heb;           // quad protocol read code
    localparam logic [7:0]  TBL_4C = 8'h0c;           // erase type 1 size exponent
    localparam logic [7:0]  TBL_4D = 8'h20;           // erase type 1 command
    localparam logic [7:0]  TBL_4E = 8'h10;           // erase type 2 size exponent
    localparam logic [7:0]  TBL_4F = 8'hd8;           // erase type 2 command
    localparam logic [7:0]  TBL_ABS = 8'h00;          // absent erase types
    localparam logic [7:0]  TBL_RSV = 8'hff;          // reserved location

    // ****************************************
    // sequencer states, gray along the path
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_CMD    = 3'h1,
        ST_ADDR   = 3'h3,
        ST_DUMMY  = 3'h2,
        ST_DATA   = 3'h6,
        ST_IGNORE = 3'h7
    } sfr_state_t;

endpackage

//--- src/sfr_read_path.sv
// serial flash read path: command decode, address, dummies, data stream
`timescale 1ns/1ps
module sfr_read_path (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        CS_N,
    input  wire logic        SCLK,
    input  wire logic [3:0]  IO_LANE_IN,
    input  wire logic [1:0]  PROTOCOL,
    input  wire logic        MEM_LOAD_EN,
    input  wire logic [20:0] MEM_LOAD_ADDR,
    input  wire logic [7:0]  MEM_LOAD_DATA,
    output logic      [3:0]  IO_LANE_OUT,
    output logic      [3:0]  IO_LANE_OE_N,
    output logic             READ_ACTIVE
);

    // ****************************************
    // helper functions
    // ****************************************

    // shift lanes into a word, highest lane first
    function automatic logic [23:0] shift_in(input logic [23:0] v, input logic [2:0] lw,
                                             input logic [3:0] io);
        unique case (lw)
            3'h2:    shift_in = {v[21:0], io[1:0]};
            3'h4:    shift_in = {v[19:0], io[3:0]};
            default: shift_in = {v[22:0], io[0]};
        endcase
    endfunction

    // parameter table byte at a location
    function automatic logic [7:0] table_byte(input logic [7:0] a);
        unique case (a)
            8'h3e:   table_byte = sfr_pkg::TBL_3E;
            8'h3f:   table_byte = sfr_pkg::TBL_3F;
            8'h40:   table_byte = sfr_pkg::TBL_40;           // RULE11
            8'h46:   table_byte = sfr_pkg::TBL_46;
            8'h47:   table_byte = sfr_pkg::TBL_47;
            8'h4a:   table_byte = sfr_pkg::TBL_4A;
            8'h4b:   table_byte = sfr_pkg::TBL_4B;
            8'h4c:   table_byte = sfr_pkg::TBL_4C;           // RULE12
            8'h4d:   table_byte = sfr_pkg::TBL_4D;           // RULE12
            8'h4e:   table_byte = sfr_pkg::TBL_4E;           // RULE13
            8'h4f:   table_byte = sfr_pkg::TBL_4F;           // RULE13
            8'h50, 8'h51, 8'h52, 8'h53:
                     table_byte = sfr_pkg::TBL_ABS;          // RULE13
            default: table_byte = sfr_pkg::TBL_RSV;          // RULE14
        endcase
    endfunction

    // ****************************************
    // storage and synchronisers
    // ****************************************
    logic [7:0]  mem [sfr_pkg::MEM_BYTES];   // read array, loaded from user side
    logic        sclk_m_q, sclk_s_q, sclk_d_q; // serial clock sync and delay
    logic        cs_m_q, cs_s_q;             // select sync
    logic [3:0]  io_m_q, io_s_q;             // lane input sync

    // ****************************************
    // sequencer registers
    // ****************************************
    sfr_pkg::sfr_state_t state_q;            // current phase
    logic [4:0]  cnt_q;                      // bits or clocks in phase
    logic [23:0] sh_q;                       // incoming shift word
    logic [7:0]  cmd_q;                      // latched command
    logic [23:0] addr_q;                     // streaming address
    logic [7:0]  data_q;                     // byte being shifted out
    logic [3:0]  pos_q;                      // bits of byte already sent

    // ****************************************
    // decode (continuous)
    // ****************************************
    wire         rise    = sclk_s_q & ~sclk_d_q;   // serial clock rising
    wire         fall    = ~sclk_s_q & sclk_d_q;   // serial clock falling
    wire         sel     = ~cs_s_q;                // select asserted
    wire         is_ext  = (PROTOCOL == sfr_pkg::PROTO_EXT);
    wire         is_dual = (PROTOCOL == sfr_pkg::PROTO_DUAL);
    wire         is_quad = (PROTOCOL == sfr_pkg::PROTO_QUAD);
    // command lines follow the protocol
    wire [2:0]   cmd_lw  = is_quad ? 3'h4 : (is_dual ? 3'h2 : 3'h1);
    wire [23:0]  cmd_sh  = shift_in(sh_q, cmd_lw, io_s_q);   // word after this rise
    wire [7:0]   cmd_now = cmd_sh[7:0];                      // code on last bit

    // support per protocol; supported codes act alike within the dual or within the quad protocol
    wire         cmd_ok  = (cmd_now == sfr_pkg::CMD_TABLE) | (cmd_now == sfr_pkg::CMD_FAST)
                         | (is_ext & ((cmd_now == sfr_pkg::CMD_READ)
                                    | (cmd_now == sfr_pkg::CMD_DOUT)
                                    | (cmd_now == sfr_pkg::CMD_DIO)
                                    | (cmd_now == sfr_pkg::CMD_QOUT)
                                    | (cmd_now == sfr_pkg::CMD_QIO)))
                         | (is_dual & ((cmd_now == sfr_pkg::CMD_DOUT)
                                     | (cmd_now == sfr_pkg::CMD_DIO)))
                         | (is_quad & ((cmd_now == sfr_pkg::CMD_QOUT)
                                     | (cmd_now == sfr_pkg::CMD_QIO)));  // RULE7

    // address lines: io variants widen extended protocol
    wire [2:0]   addr_lw = !is_ext ? cmd_lw
                         : (cmd_q == sfr_pkg::CMD_DIO) ? 3'h2                 // RULE8
                         : (cmd_q == sfr_pkg::CMD_QIO) ? 3'h4 : 3'h1;

    // data lines per command and protocol
    wire [2:0]   data_lw = !is_ext ? cmd_lw
                         : ((cmd_q == sfr_pkg::CMD_DOUT) | (cmd_q == sfr_pkg::CMD_DIO)) ? 3'h2
                         : ((cmd_q == sfr_pkg::CMD_QOUT) | (cmd_q == sfr_pkg::CMD_QIO)) ? 3'h4
                         : 3'h1;

    // dummy clocks; the mode bit rides inside them
    wire [4:0]   dummy_n = (cmd_q == sfr_pkg::CMD_READ) ? sfr_pkg::DUMMY_NONE
                         : (is_quad | (cmd_q == sfr_pkg::CMD_QIO)) ? sfr_pkg::DUMMY_QUAD // RULE10
                         : sfr_pkg::DUMMY_STD;                                 // RULE6 RULE8 RULE9

    wire [23:0]  addr_new = shift_in(sh_q, addr_lw, io_s_q);  // full address RULE1
    wire [23:0]  addr_nxt = {3'h0, addr_q[20:0] + 21'h1};    // wraps past top RULE15
    wire         cmd_done = (cnt_q + 5'(cmd_lw)) == sfr_pkg::CMD_BITS;
    wire         addr_done = (cnt_q + 5'(addr_lw)) == sfr_pkg::ADDR_BITS;
    wire         dum_done = (cnt_q + 5'h1) == dummy_n;
    wire [3:0]   pos_nxt  = pos_q + 4'(data_lw);
    wire         byte_end = (pos_nxt == sfr_pkg::BYTE_BITS);

    // byte fetch from array or table
    wire [7:0]   fetch_cur = (cmd_q == sfr_pkg::CMD_TABLE) ? table_byte(addr_new[7:0])
                           : mem[addr_new[sfr_pkg::MEM_AW-1:0]];
    wire [7:0]   fetch_nxt = (cmd_q == sfr_pkg::CMD_TABLE) ? table_byte(addr_nxt[7:0])
                           : mem[addr_nxt[sfr_pkg::MEM_AW-1:0]];
    wire [7:0]   fetch_dum = (cmd_q == sfr_pkg::CMD_TABLE) ? table_byte(addr_q[7:0])
                           : mem[addr_q[sfr_pkg::MEM_AW-1:0]];

    // lane pattern for the next bits, msb first
    wire [7:0]   out_sh   = data_q << pos_q;
    wire [3:0]   lane_val = (data_lw == 3'h4) ? out_sh[7:4]
                          : (data_lw == 3'h2) ? {2'h0, out_sh[7:6]}
                          : {2'h0, out_sh[7], 1'h0};
    wire [3:0]   lane_oe  = (data_lw == 3'h4) ? 4'h0 : (data_lw == 3'h2) ? 4'hc : 4'hd;

    // ****************************************
    // user-side array load
    // ****************************************
    always_ff @(posedge CLK) begin
        if (MEM_LOAD_EN) begin
            mem[MEM_LOAD_ADDR] <= MEM_LOAD_DATA;
        end
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sclk_m_q <= 1'h0;
            sclk_s_q <= 1'h0;
            sclk_d_q <= 1'h0;
            cs_m_q   <= 1'h1;
            cs_s_q   <= 1'h1;
            io_m_q   <= 4'h0;
            io_s_q   <= 4'h0;
        end else begin
            sclk_m_q <= SCLK;
            sclk_s_q <= sclk_m_q;
            sclk_d_q <= sclk_s_q;       // edge detect reads only synced copy
            cs_m_q   <= CS_N;
            cs_s_q   <= cs_m_q;
            io_m_q   <= IO_LANE_IN;
            io_s_q   <= io_m_q;
        end
    end

    // ****************************************
    // phase sequencer, inputs on rising edges
    // ****************************************
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= sfr_pkg::ST_IDLE;
            cnt_q   <= 5'h0;
            sh_q    <= 24'h0;
            cmd_q   <= 8'h0;
        end else if (!sel) begin
            state_q <= sfr_pkg::ST_IDLE;        // select high ends anything RULE5
            cnt_q   <= 5'h0;
        end else if (state_q == sfr_pkg::ST_IDLE) begin
            state_q <= sfr_pkg::ST_CMD;         // host opened a frame RULE2
            cnt_q   <= 5'h0;
        end else if (rise) begin
            unique case (state_q)
                sfr_pkg::ST_CMD: begin
                    sh_q  <= shift_in(sh_q, cmd_lw, io_s_q);
                    cnt_q <= cmd_done ? 5'h0 : cnt_q + 5'(cmd_lw);
                    if (cmd_done) begin
                        cmd_q   <= cmd_now;
                        state_q <= cmd_ok ? sfr_pkg::ST_ADDR : sfr_pkg::ST_IGNORE;
                    end
                end
                sfr_pkg::ST_ADDR: begin
                    sh_q  <= addr_new;          // sampled on rising edge RULE3
                    cnt_q <= addr_done ? 5'h0 : cnt_q + 5'(addr_lw);
                    if (addr_done) begin
                        state_q <= (dummy_n == sfr_pkg::DUMMY_NONE) ? sfr_pkg::ST_DATA
                                                                    : sfr_pkg::ST_DUMMY;
                    end
                end
                sfr_pkg::ST_DUMMY: begin
                    cnt_q <= cnt_q + 5'h1;      // mode bit ignored in here
                    if (dum_done) begin
                        state_q <= sfr_pkg::ST_DATA; // RULE6
                    end
                end
                default: begin
                    state_q <= state_q;         // data or ignore hold till select high
                end
            endcase
        end
    end

    // ****************************************
    // address and output byte, loaded on rising edges, advanced on falling edges
    // ****************************************
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            addr_q <= 24'h0;
            data_q <= 8'h0;
            pos_q  <= 4'h0;
        end else if (rise && (state_q == sfr_pkg::ST_ADDR) && addr_done) begin
            addr_q <= addr_new;                 // RULE1
            data_q <= fetch_cur;
            pos_q  <= 4'h0;
        end else if (rise && (state_q == sfr_pkg::ST_DUMMY) && dum_done) begin
            data_q <= fetch_dum;                // refresh after possible load
            pos_q  <= 4'h0;
        end else if (fall && sel && (state_q == sfr_pkg::ST_DATA)) begin
            pos_q <= byte_end ? 4'h0 : pos_nxt;
            if (byte_end) begin
                addr_q <= addr_nxt;             // RULE4 RULE15
                data_q <= fetch_nxt;
            end
        end
    end

    // ****************************************
    // lane drivers, registered
    // ****************************************
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            IO_LANE_OUT  <= 4'h0;
            IO_LANE_OE_N <= 4'hf;
            READ_ACTIVE  <= 1'h0;
        end else if (!sel || (state_q != sfr_pkg::ST_DATA)) begin
            IO_LANE_OE_N <= 4'hf;               // release lanes RULE5
            READ_ACTIVE  <= 1'h0;
        end else if (fall) begin
            IO_LANE_OUT  <= lane_val;
            IO_LANE_OE_N <= lane_oe;            // RULE7
            READ_ACTIVE  <= 1'h1;
        end
    end

endmodule // sfr_read_path

//--- testbench/sfr_read_path_chk.sv
// port-level checker for the serial flash read path
`timescale 1ns/1ps
module sfr_read_path_chk (
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic        CS_N,
    input wire logic        SCLK,
    input wire logic [3:0]  IO_LANE_IN,
    input wire logic [1:0]  PROTOCOL,
    input wire logic        MEM_LOAD_EN,
    input wire logic [20:0] MEM_LOAD_ADDR,
    input wire logic [7:0]  MEM_LOAD_DATA,
    input wire logic [3:0]  IO_LANE_OUT,
    input wire logic [3:0]  IO_LANE_OE_N,
    input wire logic        READ_ACTIVE
);
    // ****************************************
    // helper counters
    // ****************************************
    logic [3:0] cs_hi_q;    // cycles with select high, saturating
    logic [3:0] cs_hi_d;    // next value
    logic [5:0] rise_q;     // serial clock rises this frame, saturating
    logic [5:0] rise_d;     // next value
    logic       sclk_q;     // serial clock one cycle ago
    assign cs_hi_d = !CS_N ? 4'h0 : (cs_hi_q == 4'hf) ? cs_hi_q : cs_hi_q + 4'h1;
    assign rise_d  = CS_N ? 6'h00 : (SCLK && !sclk_q && rise_q != 6'h3f) ? rise_q + 6'h01 : rise_q;
    // counters clear on reset
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cs_hi_q <= 4'h0;
            rise_q  <= 6'h00;
            sclk_q  <= 1'h0;
        end else begin
            cs_hi_q <= cs_hi_d;
            rise_q  <= rise_d;
            sclk_q  <= SCLK;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // ****************************************
    // assertions
    // ****************************************
    cs_release_a: assert property ($rose(CS_N) |-> ##[1:5] IO_LANE_OE_N == 4'hf)
        else $error("lanes not released after select rise");
    idle_quiet_a: assert property (cs_hi_q >= 4'h6 |-> IO_LANE_OE_N == 4'hf)
        else $error("lanes driven while deselected");
    active_quiet_a: assert property (cs_hi_q >= 4'h6 |-> !READ_ACTIVE)
        else $error("read active while deselected");
    drive_flag_a: assert property (IO_LANE_OE_N != 4'hf |-> READ_ACTIVE)
        else $error("lanes driven without read active");
    oe_shape_a: assert property (IO_LANE_OE_N inside {4'hf, 4'hd, 4'hc, 4'h0})
        else $error("illegal lane enable pattern");
    dual_lanes_a: assert property (PROTOCOL == sfr_pkg::PROTO_DUAL && IO_LANE_OE_N != 4'hf
        |-> IO_LANE_OE_N == 4'hc)
        else $error("dual protocol not on two lanes");
    quad_lanes_a: assert property (PROTOCOL == sfr_pkg::PROTO_QUAD && IO_LANE_OE_N != 4'hf
        |-> IO_LANE_OE_N == 4'h0)
        else $error("quad protocol not on four lanes");
    drive_start_a: assert property (IO_LANE_OE_N != 4'hf && $past(IO_LANE_OE_N) == 4'hf
        |-> rise_q >= ((PROTOCOL == sfr_pkg::PROTO_QUAD) ? 6'h12 : 6'h18))
        else $error("data driven before header done");
    out_low_phase_a: assert property (IO_LANE_OE_N != 4'hf && $changed(IO_LANE_OUT)
        |-> !SCLK)
        else $error("lane changed while clock high");
    // main scenarios seen
    quad_seen_c: cover property (IO_LANE_OE_N == 4'h0);
    dual_seen_c: cover property (IO_LANE_OE_N == 4'hc);
    abort_seen_c: cover property ($rose(CS_N) && READ_ACTIVE);
endmodule // sfr_read_path_chk

//--- testbench/sfr_host_model.sv
// serial host model: sends command, address, dummies and gathers data
`timescale 1ns/1ps
module sfr_host_model (
    input  wire logic       clk,
    output logic            cs_n,
    output logic            sclk,
    output logic [3:0]      lane_drv,
    input  wire logic [3:0] lane_in
);
    logic [7:0] rx_q [0:23];    // bytes gathered in the last frame
    // idle: deselected, clock parked low
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        lane_drv = 4'h0;
    end
    // ****************************************
    // one serial clock: fall and launch, rise and sample
    // ****************************************
    task automatic bit_cycle(input logic [3:0] v, output logic [3:0] s);
        sclk = 1'b0;
        lane_drv = v;
        repeat (4) @(posedge clk);
        #1 sclk = 1'b1;
        s = lane_in;
        repeat (4) @(posedge clk);
        #1;
    endtask
    // msb first, w bits per clock
    task automatic shift_out(input logic [31:0] val, input int bits, input int w);
        logic [3:0] s;
        for (int i = 0; i < bits / w; i++) begin
            bit_cycle(4'((val >> (bits - w * (i + 1))) & ((32'h1 << w) - 1)), s);
        end
    endtask
    // ****************************************
    // whole frame, nbits data bits then deselect
    // ****************************************
    task automatic frame(input logic [7:0] cmd, input logic [23:0] addr, input int cw,
                         input int aw, input int dw, input int dummies, input int nbits);
        logic [3:0] s;
        logic [7:0] b;
        cs_n = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        shift_out({24'h0, cmd}, 8, cw);
        shift_out({8'h0, addr}, 24, aw);
        for (int i = 0; i < dummies; i++) bit_cycle(~lane_drv, s);
        b = 8'h00;
        for (int i = 0; i < nbits / dw; i++) begin
            bit_cycle(~lane_drv, s); // released lanes flip each clock
            b = (dw == 1) ? {b[6:0], s[1]} : (dw == 2) ? {b[5:0], s[1:0]} : {b[3:0], s};
            if (((i + 1) * dw) % 8 == 0) rx_q[((i + 1) * dw) / 8 - 1] = b;
        end
        sclk = 1'b0;
        repeat (4) @(posedge clk);
        #1 cs_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
    endtask
endmodule // sfr_host_model

//--- testbench/testbench.sv
// self-checking bench for the serial flash read path
`timescale 1ns/1ps
module testbench;
    logic        clk;           // 20 MHz
    logic        rst_n;         // async reset
    logic [1:0]  protocol;      // active protocol
    logic        load_en;       // array write strobe
    logic [20:0] load_addr;     // array write index
    logic [7:0]  load_data;     // array write value
    logic [3:0]  dev_out;       // device lane values
    logic [3:0]  dev_oe_n;      // device lane enables
    logic        read_active;   // device streaming
    logic        cs_n;          // host select
    logic        sclk;          // host clock
    logic [3:0]  host_drv;      // host lane values
    logic [3:0]  lane_w;        // resolved lane levels
    int          err_total;     // mismatches
    int          checks;        // comparisons
    int          drive_cnt;     // cycles any lane driven
    logic [7:0]  tbl_exp [0:21] = '{8'h28, 8'hbb, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
        8'h28, 8'hbb, 8'hff, 8'hff, 8'h2a, 8'heb, 8'h0c, 8'h20, 8'h10, 8'hd8,
        8'h00, 8'h00, 8'h00, 8'h00};   // table bytes 3e..53
    assign lane_w = (~dev_oe_n & dev_out) | (dev_oe_n & host_drv);
    sfr_read_path i_dut (.CLK(clk), .RST_N(rst_n), .CS_N(cs_n), .SCLK(sclk),
        .IO_LANE_IN(lane_w), .PROTOCOL(protocol), .MEM_LOAD_EN(load_en),
        .MEM_LOAD_ADDR(load_addr), .MEM_LOAD_DATA(load_data), .IO_LANE_OUT(dev_out),
        .IO_LANE_OE_N(dev_oe_n), .READ_ACTIVE(read_active));
    sfr_host_model i_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .lane_drv(host_drv),
        .lane_in(lane_w));
    // clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // drive watch for refused frames
    always @(posedge clk) if (dev_oe_n != 4'hf) drive_cnt++;
    // ****************************************
    // helpers
    // ****************************************
    task automatic complete_run();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic compare_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic compare_lanes(input logic [3:0] got, input logic [3:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    function automatic logic [7:0] exp_val(input logic [7:0] cmd, input logic [20:0] a);
        if (cmd != sfr_pkg::CMD_TABLE) return a[7:0] ^ {a[20:16], 3'h5};
        return (a[7:0] >= 8'h3e && a[7:0] <= 8'h53) ? tbl_exp[a[7:0] - 8'h3e] : 8'hff;
    endfunction
    task automatic load(input logic [20:0] a);
        @(posedge clk);
        #1 load_en = 1'b1;
        load_addr = a;
        load_data = exp_val(8'h00, a);
        @(posedge clk);
        #1 load_en = 1'b0;
    endtask
    // one read frame; lanes per command and protocol, then judged
    task automatic run_read(input logic [7:0] cmd, input logic [1:0] p, input logic [23:0] a,
                            input int nbits, input logic refused);
        int cw;
        int aw;
        int dw;
        int dm;
        int d0;
        cw = (p == sfr_pkg::PROTO_DUAL) ? 2 : (p == sfr_pkg::PROTO_QUAD) ? 4 : 1;
        aw = (cw > 1) ? cw : (cmd == 8'hbb) ? 2 : (cmd == 8'heb) ? 4 : 1;
        dw = (cw > 1) ? cw : (cmd inside {8'h3b, 8'hbb}) ? 2 : (cmd inside {8'h6b, 8'heb}) ? 4 : 1;
        dm = (cmd == 8'h03) ? 0 : (cmd == 8'heb || cw == 4) ? 10 : 8;
        protocol = p;
        d0 = drive_cnt;
        i_host.frame(cmd, a, cw, aw, dw, dm, nbits);
        if (refused) compare_byte(8'(drive_cnt - d0), 8'h00, "refused frame drove");
        else for (int k = 0; k < nbits / 8; k++)
            compare_byte(i_host.rx_q[k], exp_val(cmd, a[20:0] + 21'(k)), "read byte");
        compare_lanes(dev_oe_n, 4'hf, "lanes after frame");
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        compare_lanes(dev_oe_n, 4'hf, "reset enables");
        compare_lanes({dev_out[2:0], read_active}, 4'h0, "reset outputs");
    endtask
    task automatic t_modes();
        logic [7:0] cmds [0:9] = '{8'h03, 8'h0b, 8'h3b, 8'hbb, 8'h6b, 8'heb, 8'h0b, 8'h3b,
                                   8'hbb, 8'h0b};
        for (int i = 0; i < 10; i++)
            run_read(cmds[i], (i < 6) ? 2'h0 : (i < 9) ? 2'h1 : 2'h2, 24'he00010, 16, 1'b0);
        run_read(8'h6b, 2'h2, 24'h000012, 16, 1'b0);
        run_read(8'heb, 2'h2, 24'h000014, 16, 1'b0);
    endtask
    task automatic t_wrap();
        run_read(8'h0b, 2'h0, 24'h1ffffe, 32, 1'b0);
    endtask
    task automatic t_table();
        run_read(8'h5a, 2'h0, 24'h00003e, 176, 1'b0);
        run_read(8'h5a, 2'h0, 24'h000060, 8, 1'b0);
        run_read(8'h5a, 2'h1, 24'h00004c, 16, 1'b0);
    endtask
    task automatic t_abort();
        run_read(8'h0b, 2'h0, 24'h000010, 11, 1'b0);
        compare_lanes({3'h0, read_active}, 4'h0, "active after abort");
        run_read(8'hbb, 2'h0, 24'h000015, 8, 1'b0);
    endtask
    task automatic t_refuse();
        run_read(8'h03, 2'h1, 24'h000010, 8, 1'b1);
        run_read(8'h3b, 2'h2, 24'h000010, 8, 1'b1);
    endtask
    // watchdog
    initial begin
        #1000000;
        err_total++;
        complete_run();
    end
    // main sequence
    initial begin
        err_total = 0;
        checks = 0;
        drive_cnt = 0;
        rst_n = 1'b0;
        protocol = 2'h0;
        load_en = 1'b0;
        load_addr = 21'h0;
        load_data = 8'h00;
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        t_reset();
        for (int i = 0; i < 8; i++) load(21'h000010 + 21'(i));
        for (int i = 0; i < 4; i++) load(21'h1ffffe + 21'(i));
        t_modes();
        t_wrap();
        t_table();
        t_abort();
        t_refuse();
        complete_run();
    end
endmodule // testbench
bind sfr_read_path sfr_read_path_chk i_chk (.CLK(CLK), .RST_N(RST_N), .CS_N(CS_N),
    .SCLK(SCLK), .IO_LANE_IN(IO_LANE_IN), .PROTOCOL(PROTOCOL), .MEM_LOAD_EN(MEM_LOAD_EN),
    .MEM_LOAD_ADDR(MEM_LOAD_ADDR), .MEM_LOAD_DATA(MEM_LOAD_DATA),
    .IO_LANE_OUT(IO_LANE_OUT), .IO_LANE_OE_N(IO_LANE_OE_N), .READ_ACTIVE(READ_ACTIVE));
